/* hdl/vmdma_top.sv */
// Vector-to-DMA mapping and micro DMA engine with register port.
// Assumes accept, memory ack and bus strobes come from sys_clk logic.
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module vmdma_top
  import vmdma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire logic [15:0] acc_vector,
  output vmdma_resp_t resp,
  output logic [15:0] fall_vector_ff,
  output logic fall_valid_ff,
  output logic busy_ff,
  output vmdma_mem_t mem,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_priv,
  output logic [31:0] bus_rdata_ff,
  output logic irq_ff
);
  // ==========================================================
  // Registers and engine state
  logic [31:0] src_ff [VMDMA_CHANS];
  logic [31:0] dst_ff [VMDMA_CHANS];
  logic [15:0] cnt_ff [VMDMA_CHANS];
  logic [3:0] mode_ff [VMDMA_CHANS];
  logic [4:0] sv_ff [VMDMA_CHANS];
  logic [VMDMA_EV_W-1:0] stat_ff;
  logic [VMDMA_EV_W-1:0] mask_ff;
  vmdma_state_t state_ff;
  logic [1:0] ch_ff;
  logic beat_ff;
  logic [15:0] data_ff;
  vmdma_resp_t resp_ff;
  vmdma_mem_t mem_ff;
  logic done_ev;
  logic fall_ev;
  assign resp = resp_ff;
  assign mem = mem_ff;

  // ==========================================================
  // Vector decode
  logic [4:0] acc_sv;
  logic sv_eligible;
  logic [VMDMA_CHANS-1:0] hit;
  logic any_hit;
  logic [1:0] hit_ch;
  assign acc_sv = acc_vector[VMDMA_VEC_SHIFT +: 5];
  // Traps sit below the first window entry; reserved slots are fenced
  assign sv_eligible = (acc_vector[15:9] == 7'h00)
    && (acc_sv >= VMDMA_SV_FIRST) && (acc_sv <= VMDMA_SV_LAST)
    && (acc_sv != VMDMA_SV_RSVD);
  generate
    for (genvar g = 0; g < VMDMA_CHANS; g++) begin : g_hit
      assign hit[g] = sv_eligible && (sv_ff[g] == acc_sv);
    end
  endgenerate
  assign any_hit = |hit;
  // Lowest channel wins if software programs two alike
  always_comb begin
    hit_ch = 2'h0;
    for (int i = VMDMA_CHANS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_ch = 2'(i);
      end
    end
  end

  logic take;
  assign take = acc_valid && (state_ff == VMDMA_IDLE);

  // ==========================================================
  // Acceptance answer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resp_ff <= '0;
    end else begin
      resp_ff.valid <= take;
      resp_ff.dma <= take && any_hit;
      resp_ff.chan <= hit_ch;
      resp_ff.vector <= acc_vector;
    end
  end

  // ==========================================================
  // Engine
  logic [3:0] cur_mode;
  logic refresh_m;
  logic counter_m;
  logic [31:0] step;
  logic [15:0] cnt_dec;
  assign cur_mode = mode_ff[ch_ff];
  assign refresh_m = (cur_mode == {VMDMA_M_SPEC, 1'b0});
  assign counter_m = (cur_mode == {VMDMA_M_SPEC, 1'b1});
  assign step = cur_mode[0] ? VMDMA_STEP_WORD : VMDMA_STEP_BYTE;
  assign cnt_dec = cnt_ff[ch_ff] - 16'h0001;

  logic nxt_beat;
  assign nxt_beat = ~beat_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= VMDMA_IDLE;
      ch_ff <= 2'h0;
      beat_ff <= 1'b0;
      data_ff <= 16'h0000;
      mem_ff <= '0;
    end else begin
      unique case (state_ff)
        VMDMA_IDLE: begin
          beat_ff <= 1'b0;
          if (take && any_hit) begin
            ch_ff <= hit_ch;
            state_ff <= (mode_ff[hit_ch] == {VMDMA_M_SPEC, 1'b1}) ?
              VMDMA_UPDATE : VMDMA_READ;
          end
        end
        VMDMA_READ: begin
          mem_ff.sys_space <= 1'b1;
          mem_ff.word <= refresh_m | cur_mode[0];
          mem_ff.addr <= src_ff[ch_ff][23:0] +
            (beat_ff ? 24'h000002 : 24'h000000);
          if (mem_ff.rd && mem_ack) begin
            mem_ff.rd <= 1'b0;
            data_ff <= mem_rdata;
            if (refresh_m && !beat_ff) begin
              beat_ff <= nxt_beat;
            end else begin
              state_ff <= refresh_m ? VMDMA_UPDATE : VMDMA_WRITE;
            end
          end else begin
            mem_ff.rd <= 1'b1;
          end
        end
        VMDMA_WRITE: begin
          mem_ff.addr <= dst_ff[ch_ff][23:0];
          mem_ff.wdata <= data_ff;
          if (mem_ff.wr && mem_ack) begin
            mem_ff.wr <= 1'b0;
            state_ff <= VMDMA_UPDATE;
          end else begin
            mem_ff.wr <= 1'b1;
          end
        end
        VMDMA_UPDATE: begin
          mem_ff.sys_space <= 1'b0;
          state_ff <= VMDMA_IDLE;
        end
      endcase
    end
  end

  assign done_ev = (state_ff == VMDMA_UPDATE);
  assign fall_ev = done_ev && (cnt_dec == 16'h0000) && !refresh_m;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      fall_valid_ff <= 1'b0;
      fall_vector_ff <= 16'h0000;
    end else begin
      busy_ff <= (state_ff != VMDMA_IDLE) || (take && any_hit);
      fall_valid_ff <= fall_ev;
      fall_vector_ff <= {7'h00, sv_ff[ch_ff], 4'h0};
    end
  end

  // ==========================================================
  // Parameter registers: bus writes only with the privileged flag
  logic priv_area;
  logic [1:0] bus_ch;
  logic [3:0] bus_off;
  assign priv_area = bus_addr < VMDMA_A_PRIV_END;
  assign bus_ch = bus_addr[VMDMA_CH_SHIFT +: 2];
  assign bus_off = bus_addr[3:0];

  generate
    for (genvar c = 0; c < VMDMA_CHANS; c++) begin : g_par
      logic wsel;
      logic usel;
      assign wsel = bus_wr && bus_priv && priv_area
        && (bus_ch == 2'(c));
      assign usel = done_ev && (ch_ff == 2'(c));
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          src_ff[c] <= 32'h0000_0000;
          dst_ff[c] <= 32'h0000_0000;
          cnt_ff[c] <= 16'h0000;
          mode_ff[c] <= 4'h0;
          sv_ff[c] <= 5'h00;
        end else begin
          if (wsel && bus_off == VMDMA_A_SRC[3:0]) begin
            src_ff[c] <= bus_wdata;
          end else if (usel) begin
            if (refresh_m) begin
              src_ff[c][15:0] <= src_ff[c][15:0] + VMDMA_REFRESH_STEP;
            end else if (counter_m) begin
              src_ff[c] <= src_ff[c] + VMDMA_STEP_BYTE;
            end else if (cur_mode[3:1] == VMDMA_M_SINC) begin
              src_ff[c] <= src_ff[c] + step;
            end else if (cur_mode[3:1] == VMDMA_M_SDEC) begin
              src_ff[c] <= src_ff[c] - step;
            end
          end
          if (wsel && bus_off == VMDMA_A_DST[3:0]) begin
            dst_ff[c] <= bus_wdata;
          end else if (usel && cur_mode[3:1] == VMDMA_M_DINC) begin
            dst_ff[c] <= dst_ff[c] + step;
          end else if (usel && cur_mode[3:1] == VMDMA_M_DDEC) begin
            dst_ff[c] <= dst_ff[c] - step;
          end
          if (wsel && bus_off == VMDMA_A_CNT[3:0]) begin
            cnt_ff[c] <= bus_wdata[15:0];
          end else if (usel) begin
            cnt_ff[c] <= cnt_dec;
          end
          if (wsel && bus_off == VMDMA_A_MODE[3:0]) begin
            mode_ff[c] <= bus_wdata[3:0];
          end
          // Start vectors are ordinary I/O: no privilege needed
          if (bus_wr && bus_addr == VMDMA_A_SV + 8'(4 * c)) begin
            sv_ff[c] <= bus_wdata[4:0];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Interrupt status, mask and line
  logic [VMDMA_EV_W-1:0] ev_set;
  logic [VMDMA_EV_W-1:0] ev_clr;
  logic [VMDMA_EV_W-1:0] nxt_stat;
  logic [VMDMA_EV_W-1:0] nxt_mask;
  always_comb begin
    ev_set = '0;
    ev_set[VMDMA_EV_DONE] = done_ev;
    ev_set[ch_ff] = fall_ev;
  end
  assign ev_clr = (bus_wr && bus_addr == VMDMA_A_STAT) ?
    bus_wdata[VMDMA_EV_W-1:0] : '0;
  // Set beats clear in the same cycle
  assign nxt_stat = (stat_ff & ~ev_clr) | ev_set;
  // Line follows a mask write at once, so it never lags the mask
  assign nxt_mask = (bus_wr && bus_addr == VMDMA_A_MASK) ?
    bus_wdata[VMDMA_EV_W-1:0] : mask_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_ff <= '0;
      mask_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  // ==========================================================
  // Read port; unmapped reads and parameter reads without the privileged flag return zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (priv_area) begin
      if (bus_priv) begin
        unique case (bus_off)
          VMDMA_A_SRC[3:0]: rd_mux = src_ff[bus_ch];
          VMDMA_A_DST[3:0]: rd_mux = dst_ff[bus_ch];
          VMDMA_A_CNT[3:0]: rd_mux = {16'h0000, cnt_ff[bus_ch]};
          VMDMA_A_MODE[3:0]: rd_mux = {28'h0000000, mode_ff[bus_ch]};
          default: rd_mux = 32'h0000_0000;
        endcase
      end
    end else if (bus_addr[7:4] == VMDMA_A_SV[7:4]
      && bus_addr[1:0] == 2'h0) begin
      rd_mux = {27'h0000000, sv_ff[bus_addr[3:2]]};
    end else if (bus_addr == VMDMA_A_STAT) begin
      rd_mux = {27'h0000000, stat_ff};
    end else if (bus_addr == VMDMA_A_MASK) begin
      rd_mux = {27'h0000000, mask_ff};
    end else if (bus_addr == VMDMA_A_ENG) begin
      rd_mux = {27'h0000000, ch_ff, state_ff};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata_ff <= 32'h0000_0000;
    end else begin
      bus_rdata_ff <= bus_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_dma_take;
    take && any_hit;
  endsequence
  sequence s_dma_answer;
    resp_ff.valid && resp_ff.dma ##1 busy_ff;
  endsequence

  a_trap_no_dma: assert property (
    take && acc_vector < 16'h0080 |=> resp_ff.valid && !resp_ff.dma)
    else $error("trap vector answered as DMA");
  a_answer_each: assert property (
    s_dma_take |=> s_dma_answer)
    else $error("DMA acceptance not answered");
  a_reserved_blocked: assert property (
    take && acc_sv == VMDMA_SV_RSVD |=> !resp_ff.dma)
    else $error("reserved slot started DMA");
  a_window_only: assert property (
    take && acc_vector[15:9] != 7'h00 |=> !resp_ff.dma)
    else $error("vector outside window started DMA");
  a_fall_on_zero: assert property (
    fall_valid_ff |-> $past(cnt_dec) == 16'h0000 && state_ff == VMDMA_IDLE)
    else $error("fall-through without zero count");
  a_refresh_keeps: assert property (
    done_ev && refresh_m |=> !fall_valid_ff)
    else $error("refresh mode fell through");
  a_cnt_wraps: assert property (
    done_ev && !bus_wr && cnt_ff[ch_ff] == 16'h0000
      |=> cnt_ff[$past(ch_ff)] == 16'hFFFF)
    else $error("counter did not wrap");
  a_priv_hidden: assert property (
    bus_rd && priv_area && !bus_priv |=> bus_rdata_ff == 32'h0000_0000)
    else $error("parameter read without privilege");
  a_read_addr: assert property (
    state_ff == VMDMA_READ && mem_ff.rd && !refresh_m
      |-> mem_ff.addr == src_ff[ch_ff][23:0])
    else $error("read address differs from source pointer");
  a_irq_level: assert property (
    (|(stat_ff & mask_ff)) |-> irq_ff)
    else $error("interrupt line low with pending status");
endmodule

/* inc/vmdma_pkg.sv */
// Constants, types and register map of the vectored micro DMA block.
// Assumes one 250 MHz clock, sync active-low reset, single-cycle bus.
//
// Summary of operation
// - Trap, privilege-fault and bad-opcode vectors never start DMA.
// - DMA start vector of a source is its vector value shifted right four.
// - Four wide timer compare matches own start vectors 14H to 17H.
// - Serial receive/send events own start vectors 18H to 1BH in order.
// - Each accepted vector is answered with a DMA-or-ordinary indication.
// - Transfer parameters are reachable only by the privileged load path.
// - DMA starts only on a match with one of four programmed start vectors.
// - Move one unit, decrement counter; zero result falls through.
// - Refresh mode still decrements the counter but never falls through.
// - Pointers are 32 bits; only 24 bits drive the address outputs.
// - DMA accesses always use the system-mode address space.
// - Byte or word units; each pointer increments, decrements or stays.
// - Counter is 16 bits; start value 0000H gives 65536 transfers.
// - After fall-through the counter continues from the wrapped zero.
// - Only sources with an assigned start vector may be DMA serviced.
// - Mode bit 0 selects byte or word; upper four mode bits write as zero.
// - Refresh reads four bytes, adds four to low source half, decrements.
package vmdma_pkg;
  localparam int VMDMA_CHANS = 4;
  localparam int VMDMA_VEC_SHIFT = 4;
  // Start vector window of DMA-capable sources
  localparam logic [4:0] VMDMA_SV_FIRST = 5'h08;
  localparam logic [4:0] VMDMA_SV_LAST = 5'h1C;
  localparam logic [4:0] VMDMA_SV_RSVD = 5'h0F;
  // Register map, byte addresses
  localparam logic [7:0] VMDMA_A_SRC = 8'h00;
  localparam logic [7:0] VMDMA_A_DST = 8'h04;
  localparam logic [7:0] VMDMA_A_CNT = 8'h08;
  localparam logic [7:0] VMDMA_A_MODE = 8'h0C;
  localparam logic [7:0] VMDMA_A_PRIV_END = 8'h40;
  localparam logic [7:0] VMDMA_A_SV = 8'h40;
  localparam logic [7:0] VMDMA_A_STAT = 8'h50;
  localparam logic [7:0] VMDMA_A_MASK = 8'h54;
  localparam logic [7:0] VMDMA_A_ENG = 8'h58;
  localparam int VMDMA_CH_SHIFT = 4;
  localparam int VMDMA_EV_DONE = 4;
  localparam int VMDMA_EV_W = 5;
  // Transfer mode field codes, bits 3:1
  localparam logic [2:0] VMDMA_M_DINC = 3'h0;
  localparam logic [2:0] VMDMA_M_DDEC = 3'h1;
  localparam logic [2:0] VMDMA_M_SINC = 3'h2;
  localparam logic [2:0] VMDMA_M_SDEC = 3'h3;
  localparam logic [2:0] VMDMA_M_FIX = 3'h4;
  localparam logic [2:0] VMDMA_M_SPEC = 3'h5;
  localparam logic [15:0] VMDMA_REFRESH_STEP = 16'h0004;
  localparam logic [31:0] VMDMA_STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] VMDMA_STEP_WORD = 32'h0000_0002;

  typedef enum logic [2:0] {
    VMDMA_IDLE, VMDMA_READ, VMDMA_WRITE, VMDMA_UPDATE
  } vmdma_state_t;

  typedef struct packed {
    logic [23:0] addr;
    logic rd;
    logic wr;
    logic word;
    logic sys_space;
    logic [15:0] wdata;
  } vmdma_mem_t;

  typedef struct packed {
    logic valid;
    logic dma;
    logic [1:0] chan;
    logic [15:0] vector;
  } vmdma_resp_t;
endpackage

/* test/vmdma_mem_model.sv */
// Memory partner that answers the engine's access port.
// Assumes one access at a time, held until acknowledged.
`timescale 1ns/10ps
module vmdma_mem_model
  import vmdma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input vmdma_mem_t mem,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [15:0] mem_rdata,
  output int n_rd,
  output int n_wr,
  output logic [23:0] waddr,
  output logic [15:0] wdata,
  output logic wsys,
  output logic wword
);
  int wait_cnt;
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  // ==========================================
  // Answer after lat cycles; released data toggles
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n) begin
      wait_cnt = 0;
      n_rd = 0;
      n_wr = 0;
    end else if ((mem.rd || mem.wr) && !mem_ack) begin
      if (wait_cnt < int'(lat)) begin
        wait_cnt++;
      end else begin
        wait_cnt = 0;
        mem_ack <= 1'b1;
        if (mem.rd) begin
          n_rd++;
          mem_rdata <= {mem.addr[7:0], ~mem.addr[7:0]};
        end else begin
          n_wr++;
          waddr <= mem.addr;
          wdata <= mem.wdata;
          wsys <= mem.sys_space;
          wword <= mem.word;
        end
      end
    end
  end
endmodule

/* test/vmdma_test.sv */
// Self-checking bench for the vectored micro DMA block.
// Assumes the memory model answers every engine access.
`timescale 1ns/10ps
module vmdma_test
  import vmdma_pkg::*;
;
  typedef struct packed {
    logic [15:0] v;
    logic dma;
    logic [1:0] ch;
  } vmdma_vrow_t;
  typedef struct packed {
    logic [3:0] m;
    logic [31:0] s;
    logic [31:0] d;
    logic acc;
  } vmdma_mrow_t;
  localparam logic [31:0] S = 32'h0010_0100;
  localparam logic [31:0] D = 32'h0020_0200;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic acc_valid = 1'b0;
  logic [15:0] acc_vector = 16'h0000;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic bus_priv = 1'b0;
  logic [3:0] lat = 4'h0;
  logic mem_ack, fall_valid_ff, busy_ff, irq_ff, wsys, wword;
  logic [15:0] mem_rdata, fall_vector_ff, wdata, fvec;
  logic [31:0] bus_rdata_ff;
  logic [23:0] waddr;
  vmdma_resp_t resp;
  vmdma_mem_t mem;
  int n_errors, n_compared, n_fall, n_resp, n_rd, n_wr;
  logic [4:0] sv[4] = '{5'h14, 5'h19, 5'h1C, 5'h0F};
  vmdma_vrow_t vt[8] = '{'{16'h0010, 1'b0, 2'd0}, '{16'h0020, 1'b0, 2'd0},
    '{16'h0140, 1'b1, 2'd0}, '{16'h0190, 1'b1, 2'd1},
    '{16'h01C0, 1'b1, 2'd2}, '{16'h00F0, 1'b0, 2'd0},
    '{16'h0150, 1'b0, 2'd0}, '{16'h1140, 1'b0, 2'd0}};
  vmdma_mrow_t mt[6] = '{'{{VMDMA_M_DINC, 1'b0}, S, D + 32'h1, 1'b1},
    '{{VMDMA_M_DDEC, 1'b1}, S, D - 32'h2, 1'b1},
    '{{VMDMA_M_SINC, 1'b1}, S + 32'h2, D, 1'b1},
    '{{VMDMA_M_SDEC, 1'b0}, S - 32'h1, D, 1'b1},
    '{{VMDMA_M_FIX, 1'b1}, S, D, 1'b1},
    '{{VMDMA_M_SPEC, 1'b1}, S + 32'h1, D, 1'b0}};

  vmdma_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .acc_valid(acc_valid),
    .acc_vector(acc_vector), .resp(resp), .fall_vector_ff(fall_vector_ff),
    .fall_valid_ff(fall_valid_ff), .busy_ff(busy_ff), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_priv(bus_priv), .bus_rdata_ff(bus_rdata_ff), .irq_ff(irq_ff));
  vmdma_mem_model mdl (.sys_clk(sys_clk), .rst_n(rst_n), .mem(mem),
    .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .n_rd(n_rd),
    .n_wr(n_wr), .waddr(waddr), .wdata(wdata), .wsys(wsys),
    .wword(wword));

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Pulse monitors, counted per edge
  always @(posedge sys_clk) begin
    if (resp.valid === 1'b1) n_resp++;
    if (fall_valid_ff === 1'b1) begin
      n_fall++;
      fvec = fall_vector_ff;
    end
  end
  // ==========================================
  // Checks, bus and accept tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask
  task automatic results();
    $display("Counts: %0d compared, %0d errors", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic p);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_priv <= p;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic p,
                    output logic [31:0] q);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_priv <= p;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 q = bus_rdata_ff;
  endtask
  task automatic pulse(input logic [15:0] v);
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_vector <= v;
    @(posedge sys_clk);
    acc_valid <= 1'b0;
  endtask
  // Bounded so a stuck engine ends the run
  task automatic idle();
    int i;
    for (i = 0; i < 300 && busy_ff !== 1'b0; i++) @(posedge sys_clk);
    if (i < 300) begin
      repeat (3) @(posedge sys_clk);
    end else begin
      n_errors++;
      $display("[FAIL] busy_wait exp 0 got 1");
      results();
    end
  endtask
  task automatic acc(input logic [15:0] v, output vmdma_resp_t r);
    pulse(v);
    #1 r = resp;
    idle();
  endtask
  // ==========================================
  // Main sequence
  initial begin
    vmdma_resp_t r;
    logic [31:0] q;
    int k, nr, nw;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1 chk("rst_resp", 32'h0, 32'(resp));
    chk("rst_flags", 32'h0, 32'({busy_ff, irq_ff, fall_valid_ff}));
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      wr(8'(k * 16) + VMDMA_A_SRC, 32'hAB12_3400 + 32'(k * 16), 1'b1);
      wr(8'(k * 16) + VMDMA_A_DST, 32'hCD56_7800 + 32'(k * 16), 1'b1);
      wr(8'(k * 16) + VMDMA_A_CNT, 32'h0000_0100, 1'b1);
      wr(8'(k * 16) + VMDMA_A_MODE, 32'({VMDMA_M_FIX, 1'b1}), 1'b1);
      wr(VMDMA_A_SV + 8'(k * 4), 32'(sv[k]), 1'b0);
    end
    wr(VMDMA_A_CNT + 8'h30, 32'h0000_1234, 1'b0);
    rd(VMDMA_A_CNT + 8'h30, 1'b1, q);
    chk("cnt_priv", 32'h0000_0100, q);
    rd(VMDMA_A_CNT + 8'h30, 1'b0, q);
    chk("cnt_nopriv", 32'h0, q);
    rd(8'h7C, 1'b1, q);
    chk("unmapped", 32'h0, q);
    rd(VMDMA_A_SV + 8'h04, 1'b0, q);
    chk("sv_read", 32'(sv[1]), q);
    $display("test registers done");
    foreach (vt[i]) begin
      acc(vt[i].v, r);
      chkb("resp_valid", 1'b1, r.valid);
      chkb("resp_dma", vt[i].dma, r.dma);
      chk("resp_vec", 32'(vt[i].v), 32'(r.vector));
      if (vt[i].dma) begin
        chk("resp_chan", 32'(vt[i].ch), 32'(r.chan));
        chk("wr_addr", 32'h56_7800 + 32'(vt[i].ch * 16), 32'(waddr));
        chk("wr_data", 32'({8'(vt[i].ch * 16), ~8'(vt[i].ch * 16)}),
            32'(wdata));
        chkb("sys_space", 1'b1, wsys);
      end
    end
    $display("test vectors done");
    lat <= 4'h2;
    foreach (mt[i]) begin
      wr(VMDMA_A_SRC, S, 1'b1);
      wr(VMDMA_A_DST, D, 1'b1);
      wr(VMDMA_A_MODE, 32'(mt[i].m), 1'b1);
      nw = n_wr;
      acc(16'h0140, r);
      rd(VMDMA_A_SRC, 1'b1, q);
      chk("src_step", mt[i].s, q);
      rd(VMDMA_A_DST, 1'b1, q);
      chk("dst_step", mt[i].d, q);
      chk("unit_moved", 32'(mt[i].acc), 32'(n_wr - nw));
      if (mt[i].acc) begin
        chkb("unit_size", mt[i].m[0], wword);
      end
    end
    $display("test modes done");
    wr(VMDMA_A_MODE, 32'({VMDMA_M_SINC, 1'b1}), 1'b1);
    wr(VMDMA_A_CNT, 32'h0000_0002, 1'b1);
    wr(VMDMA_A_MASK, 32'h0, 1'b0);
    wr(VMDMA_A_STAT, 32'h0000_001F, 1'b0);
    k = n_fall;
    acc(16'h0140, r);
    chk("no_fall", 32'(k), 32'(n_fall));
    acc(16'h0140, r);
    chk("fall", 32'(k + 1), 32'(n_fall));
    chk("fall_vec", 32'h0000_0140, 32'(fvec));
    chkb("irq_masked", 1'b0, irq_ff);
    rd(VMDMA_A_STAT, 1'b0, q);
    chk("status", 32'h0000_0011, q);
    wr(VMDMA_A_MASK, 32'h0000_0001, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1 chkb("irq_on", 1'b1, irq_ff);
    acc(16'h0140, r);
    rd(VMDMA_A_CNT, 1'b1, q);
    chk("cnt_wrap", 32'h0000_FFFF, q);
    chk("no_refall", 32'(k + 1), 32'(n_fall));
    wr(VMDMA_A_STAT, 32'h0000_001F, 1'b0);
    repeat (2) @(posedge sys_clk);
    #1 chkb("irq_off", 1'b0, irq_ff);
    $display("test fall through done");
    wr(VMDMA_A_MODE, 32'({VMDMA_M_SPEC, 1'b0}), 1'b1);
    wr(VMDMA_A_SRC, 32'h0012_FFFE, 1'b1);
    wr(VMDMA_A_CNT, 32'h0000_0001, 1'b1);
    nr = n_rd;
    nw = n_wr;
    k = n_fall;
    acc(16'h0140, r);
    acc(16'h0140, r);
    chk("ref_reads", 32'h4, 32'(n_rd - nr));
    chk("ref_writes", 32'h0, 32'(n_wr - nw));
    chk("ref_nofall", 32'(k), 32'(n_fall));
    rd(VMDMA_A_SRC, 1'b1, q);
    chk("ref_src", 32'h0012_0006, q);
    $display("test refresh done");
    lat <= 4'h6;
    wr(VMDMA_A_MODE, 32'({VMDMA_M_FIX, 1'b1}), 1'b1);
    k = n_resp;
    pulse(16'h0140);
    pulse(16'h0190);
    idle();
    chk("busy_refuse", 32'(k + 1), 32'(n_resp));
    $display("test busy done");
    results();
  end
endmodule
